// ---- hw/lpc_phy_regs.sv ----
module lpc_phy_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] regAddr, // Register offset
    input wire logic [7:0] regWdata,
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    output logic [7:0] regRdata, // Valid cycle after read
    // Chip-level mode inputs and the transmit pin
    input wire logic specialMode, // Chip special mode
    input wire logic stopMode, // Chip stop mode
    input wire logic transmitInput, // Transmit pin, low is dominant
    // Pin-side controls
    output logic phyEnabled,
    output logic transmitterOn,
    output logic receiverOn,
    output logic wakeDetectOn,
    output logic strongPullup,
    output logic [1:0] slewSelect,
    output logic slewReserved,
    output logic timeoutActive,
    output logic irq
);
    // Register storage
    logic [7:0] phyControl;
    logic [7:0] slewRateMode;
    logic [7:0] factoryTestA;
    logic [7:0] factoryTestB;
    logic [7:0] irqMask;
    logic [7:0] irqFlag;
    logic dominantStatus;
    logic [15:0] domCount;
    // Operating mode state
    lpc_pkg::lpc_mode_t mode;
    lpc_pkg::lpc_mode_t next_mode;
    // Transmit pin synchroniser
    logic txSync1;
    logic txSync2;
    logic txPrev;

    // True while transmitter and receiver both run
    function automatic logic isNormal(input lpc_pkg::lpc_mode_t m);
        return m == lpc_pkg::MODE_NORMAL;
    endfunction

    // True while the layer is fully off
    function automatic logic isShutdown(input lpc_pkg::lpc_mode_t m);
        return m == lpc_pkg::MODE_SHUTDOWN;
    endfunction

    // True while the chip sleeps and the layer waits
    function automatic logic isStandby(input lpc_pkg::lpc_mode_t m);
        return m == lpc_pkg::MODE_STANDBY;
    endfunction

    // Address decode
    wire selControl = regAddr == lpc_pkg::OFF_CONTROL;
    wire selTestA = regAddr == lpc_pkg::OFF_TEST_A;
    wire selSlew = regAddr == lpc_pkg::OFF_SLEW;
    wire selTestB = regAddr == lpc_pkg::OFF_TEST_B;
    wire selStatus = regAddr == lpc_pkg::OFF_STATUS;
    wire selMask = regAddr == lpc_pkg::OFF_IRQ_MASK;
    wire selFlag = regAddr == lpc_pkg::OFF_IRQ_FLAG;
    wire enableBit = phyControl[lpc_pkg::BIT_ENABLE];
    // Write qualifiers, refused writes never reach a register
    wire wrControl = regWrite && selControl;
    wire wrTestA = regWrite && selTestA && specialMode;
    wire wrTestB = regWrite && selTestB && specialMode;
    wire wrSlew = regWrite && selSlew && !enableBit;
    wire wrMask = regWrite && selMask;
    wire wrFlagClr = regWrite && selFlag && regWdata[lpc_pkg::BIT_DTFLAG];
    // Timeout monitoring only when transmitting and not disabled
    wire monitorOn = isNormal(mode) && !slewRateMode[lpc_pkg::BIT_TODIS];
    wire txDominant = !txSync2;
    wire txFall = txPrev && !txSync2;
    wire limitHit = monitorOn && txDominant && (domCount == lpc_pkg::DOM_LIMIT);
    wire next_domStat = (limitHit || dominantStatus) && txDominant && monitorOn;
    wire setFlag = limitHit || (dominantStatus && txDominant);
    // Counter restarts on every new dominant stretch
    wire domRestart = !monitorOn || !txDominant || txFall;
    wire next_timeoutActive = next_domStat;
    // Next values of the pin-side controls
    wire next_phyEnabled = !isShutdown(mode);
    wire next_transmitterOn = isNormal(mode) && !next_domStat;
    wire next_receiverOn = isNormal(mode) || (mode == lpc_pkg::MODE_RECEIVE_ONLY_BIT);
    wire next_wakeDetectOn = isStandby(mode) && phyControl[lpc_pkg::BIT_WAKE];
    wire standbyQuiet = isStandby(mode) && !phyControl[lpc_pkg::BIT_WAKE]; // Standby, wake-up off
    wire next_strongPullup = phyControl[lpc_pkg::BIT_PULLUP] && next_phyEnabled && !standbyQuiet;
    wire next_slewReserved = slewRateMode[1:0] == 2'h3;
    wire next_irq = |(irqFlag & irqMask);

    // Read mux, status register is read-only
    logic [7:0] readMux;
    always_comb
    begin
        readMux = 8'h00;
        // Enable, receive-only, wake and pull-up bits
        if (selControl)
            readMux = phyControl & lpc_pkg::MASK_CONTROL;
        // Test register, readable in any mode
        else if (selTestA)
            readMux = factoryTestA;
        // Timeout disable and slew field
        else if (selSlew)
            readMux = slewRateMode & lpc_pkg::MASK_SLEW;
        // Second test register
        else if (selTestB)
            readMux = factoryTestB;
        // Status, only the dominant bit exists
        else if (selStatus)
            readMux = {dominantStatus, 7'h00};
        // Interrupt mask
        else if (selMask)
            readMux = irqMask;
        // Sticky interrupt flags
        else if (selFlag)
            readMux = irqFlag;
    end

    // Mode transitions
    always_comb
    begin
        next_mode = mode;
        case (mode)
            // Off, weak pull-up only
            lpc_pkg::MODE_SHUTDOWN:
            begin
                if (enableBit)
                    next_mode = phyControl[lpc_pkg::BIT_RECEIVE_ONLY_BIT] ? lpc_pkg::MODE_RECEIVE_ONLY_BIT : lpc_pkg::MODE_NORMAL;
            end
            // Full transceiver
            lpc_pkg::MODE_NORMAL:
            begin
                if (!enableBit)
                    next_mode = lpc_pkg::MODE_SHUTDOWN;
                else if (phyControl[lpc_pkg::BIT_RECEIVE_ONLY_BIT])
                    next_mode = lpc_pkg::MODE_RECEIVE_ONLY_BIT;
                else if (stopMode)
                    next_mode = lpc_pkg::MODE_STANDBY;
            end
            // Listen without driving
            lpc_pkg::MODE_RECEIVE_ONLY_BIT:
            begin
                if (!enableBit)
                    next_mode = lpc_pkg::MODE_SHUTDOWN;
                else if (!phyControl[lpc_pkg::BIT_RECEIVE_ONLY_BIT])
                    next_mode = lpc_pkg::MODE_NORMAL;
            end
            // Chip asleep, optional wake-up
            lpc_pkg::MODE_STANDBY:
            begin
                if (!enableBit)
                    next_mode = lpc_pkg::MODE_SHUTDOWN;
                else if (!stopMode)
                    next_mode = lpc_pkg::MODE_NORMAL;
            end
            // Illegal code recovers to off
            default:
                next_mode = lpc_pkg::MODE_SHUTDOWN;
        endcase
    end

    // Mode register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mode <= lpc_pkg::MODE_SHUTDOWN;
        else
            mode <= next_mode;
    end

    // Synchroniser, idle recessive high
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            txSync1 <= 1'b1;
            txSync2 <= 1'b1;
        end
        else
        begin
            txSync1 <= transmitInput;
            txSync2 <= txSync1;
        end
    end

    // Previous level for the falling-edge detector, idle high
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            txPrev <= 1'b1;
        else
            txPrev <= txSync2;
    end

    // Dominant duration counter, restarts on falling edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            domCount <= 16'h0000;
        else if (domRestart)
            domCount <= 16'h0000;
        else if (domCount != lpc_pkg::DOM_LIMIT)
            domCount <= domCount + 16'h0001;
    end

    // Control register, read and written at any time
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            phyControl <= lpc_pkg::RST_CONTROL;
        else if (wrControl)
            phyControl <= regWdata & lpc_pkg::MASK_CONTROL;
    end

    // Slew register, frozen while the layer is enabled
    // Changing the slope mid-frame would bend the bus edges
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            slewRateMode <= lpc_pkg::RST_SLEW;
        else if (wrSlew)
            slewRateMode <= regWdata & lpc_pkg::MASK_SLEW;
    end

    // First test register, special mode writes only
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            factoryTestA <= lpc_pkg::RST_TEST;
        else if (wrTestA)
            factoryTestA <= regWdata;
    end

    // Second test register, same protection
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            factoryTestB <= lpc_pkg::RST_TEST;
        else if (wrTestB)
            factoryTestB <= regWdata;
    end

    // Interrupt mask, only the timeout position exists
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irqMask <= lpc_pkg::RST_IRQ;
        else if (wrMask)
            irqMask <= regWdata & lpc_pkg::MASK_IRQ;
    end

    // Timeout status, follows the pin once a timeout has hit
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            dominantStatus <= 1'b0;
        else
            dominantStatus <= next_domStat;
    end

    // Sticky timeout flag, a set beats a clear in one cycle
    // Software cannot clear it while the pin stays dominant
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irqFlag <= lpc_pkg::RST_IRQ;
        else if (setFlag)
            irqFlag[lpc_pkg::BIT_DTFLAG] <= 1'b1;
        else if (wrFlagClr)
            irqFlag[lpc_pkg::BIT_DTFLAG] <= 1'b0;
    end

    // Read data register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            regRdata <= 8'h00;
        else if (regRead)
            regRdata <= readMux;
        else
            regRdata <= 8'h00;
    end

    // Layer on indication
    // Follows the mode, so it lags the enable bit by two cycles
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            phyEnabled <= 1'b0;
        else
            phyEnabled <= next_phyEnabled;
    end

    // Transmitter enable
    // Dropped in the same cycle the timeout status rises
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            transmitterOn <= 1'b0;
        else
            transmitterOn <= next_transmitterOn;
    end

    // Receiver enable
    // Runs in normal and receive-only modes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            receiverOn <= 1'b0;
        else
            receiverOn <= next_receiverOn;
    end

    // Bus wake-up detector enable
    // Only in standby and only when software allows it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            wakeDetectOn <= 1'b0;
        else
            wakeDetectOn <= next_wakeDetectOn;
    end

    // Strong pull-up select
    // Weak pull-up alone keeps the bus recessive when off
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            strongPullup <= 1'b0;
        else
            strongPullup <= next_strongPullup;
    end

    // Slew field copy for the slope control
    // Reserved code passes through and is flagged separately
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            slewSelect <= lpc_pkg::SLEW_NORMAL;
        else
            slewSelect <= slewRateMode[1:0];
    end

    // Reserved slew code indication
    // Lets the analog side fall back on a safe slope
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            slewReserved <= 1'b0;
        else
            slewReserved <= next_slewReserved;
    end

    // Timeout in force, a copy of the status bit
    // High exactly while the timeout holds the transmitter off
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            timeoutActive <= 1'b0;
        else
            timeoutActive <= next_timeoutActive;
    end

    // Interrupt line, one cycle behind the flag
    // Level output, high while an unmasked flag is set
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= next_irq;
    end
endmodule

// ---- hw/lpc_pkg.sv ----
// Function
// - Enable bit three enables, zero shuts down
// - Shutdown: only weak pull-up, registers accessible
// - Receive-only bit two selects receive-only mode
// - Wake bit one enables standby wake-up
// - Pull-up bit selects strong unless disabled/standby; code keeps strong in standby while wake-up is on
// - Control register read and written anytime
// - Test registers writable only in special mode
// - Slew register writable only while disabled
// - Slew bit seven disables dominant timeout
// - Slew field: normal, slow, fast, reserved
// - Status register ignores all writes
// - Status bit seven while transmit stays dominant
// - Timeout holds transmitter off, flag re-sets
// - Dominant past limit sets flag, disables transmitter
// - Writing one clears flag, zero no effect
// - Enable leaves shutdown into normal or receive-only
// - Stop mode moves normal into standby
package lpc_pkg;
    // Register offsets
    localparam logic [3:0] OFF_CONTROL = 4'h1;
    localparam logic [3:0] OFF_TEST_A = 4'h2;
    localparam logic [3:0] OFF_SLEW = 4'h3;
    localparam logic [3:0] OFF_TEST_B = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h5;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
    localparam logic [3:0] OFF_IRQ_FLAG = 4'h7;
    // Field positions
    localparam int BIT_ENABLE = 3;
    localparam int BIT_RECEIVE_ONLY_BIT = 2;
    localparam int BIT_WAKE = 1;
    localparam int BIT_PULLUP = 0;
    localparam int BIT_TODIS = 7;
    localparam int BIT_DTSTAT = 7;
    localparam int BIT_DTFLAG = 7;
    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_SLEW = 8'h00;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;
    // Writable bit masks
    localparam logic [7:0] MASK_CONTROL = 8'h0f;
    localparam logic [7:0] MASK_SLEW = 8'h83;
    localparam logic [7:0] MASK_IRQ = 8'h80;
    // Slew field codes
    localparam logic [1:0] SLEW_NORMAL = 2'h0;
    localparam logic [1:0] SLEW_SLOW = 2'h1;
    localparam logic [1:0] SLEW_FAST = 2'h2;
    // Dominant time limit
    localparam int CLK_MHZ = 100;
    localparam int DOM_LIMIT_US = 10;
    localparam int DOM_LIMIT_CYC = DOM_LIMIT_US * CLK_MHZ;
    localparam logic [15:0] DOM_LIMIT = 16'(DOM_LIMIT_CYC);
    // Operating modes
    typedef enum logic [3:0]
    {
        MODE_SHUTDOWN = 4'b0001,
        MODE_NORMAL = 4'b0010,
        MODE_RECEIVE_ONLY_BIT = 4'b0100,
        MODE_STANDBY = 4'b1000
    } lpc_mode_t;
endpackage

// ---- verification/lpc_props.sv ----
module lpc_props
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic stopMode,
    input wire logic transmitInput,
    input wire logic phyEnabled,
    input wire logic transmitterOn,
    input wire logic strongPullup,
    input wire logic timeoutActive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lowCount; // Raw dominant cycles
    // Saturating count of dominant cycles
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            lowCount <= 16'h0000;
        else if (transmitInput)
            lowCount <= 16'h0000;
        else if (lowCount != 16'hffff)
            lowCount <= lowCount + 16'h0001;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Control writes that set or clear enable
    sequence enWrite;
        regWrite && regAddr == lpc_pkg::OFF_CONTROL && regWdata[3] && !stopMode;
    endsequence
    sequence disWrite;
        regWrite && regAddr == lpc_pkg::OFF_CONTROL && !regWdata[3];
    endsequence
    read_idle_a: assert property (!regRead |=> regRdata == 8'h00)
        else $error("read data not zero");
    ctrl_bits_a: assert property (regRead && regAddr == lpc_pkg::OFF_CONTROL |=> regRdata[7:4] == 4'h0)
        else $error("control upper bits set");
    slew_bits_a: assert property (regRead && regAddr == lpc_pkg::OFF_SLEW |=> regRdata[6:2] == 5'h00)
        else $error("slew middle bits set");
    shutdown_pull_a: assert property (disWrite ##1 (!regWrite) [*4] |-> !strongPullup && !transmitterOn)
        else $error("shutdown drives pins");
    timeout_tx_a: assert property (timeoutActive |-> !transmitterOn)
        else $error("transmitter on in timeout");
    timeout_clear_a: assert property (transmitInput [*5] |-> !timeoutActive)
        else $error("timeout stuck");
    timeout_limit_a: assert property ($rose(timeoutActive) |-> lowCount >= lpc_pkg::DOM_LIMIT)
        else $error("timeout too early");
    enable_on_a: assert property (enWrite |-> ##[1:4] phyEnabled)
        else $error("enable ignored");
    disable_off_a: assert property (disWrite |-> ##[1:4] !phyEnabled)
        else $error("disable ignored");
endmodule
bind lpc_phy_regs lpc_props i_props (.clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .stopMode, .transmitInput, .phyEnabled, .transmitterOn, .strongPullup, .timeoutActive);

// ---- verification/lpc_tx_partner.sv ----
module lpc_tx_partner
(
    input wire logic clk,
    input wire logic reset,
    input wire logic holdStart, // Start a dominant stretch
    input wire logic [15:0] holdCycles,
    output logic transmitInput // Low is dominant
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left; // Dominant cycles to go
    // Load a stretch and count it out
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            left <= 16'h0000;
        else if (holdStart)
            left <= holdCycles;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
    // Idle line sits recessive on its pull-up
    assign transmitInput = (left == 16'h0000);
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, specialMode = 1'b0, stopMode = 1'b0;
    logic holdStart = 1'b0, transmitInput, phyEnabled, transmitterOn, receiverOn, wakeDetectOn, strongPullup;
    logic slewReserved, timeoutActive, irq;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic [15:0] holdCycles = 16'h0000; // Dominant stretch
    logic [1:0] slewSelect;
    int fails = 0, totalChecks = 0;
    lpc_phy_regs i_dut (.clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .specialMode,
        .stopMode, .transmitInput, .phyEnabled, .transmitterOn, .receiverOn, .wakeDetectOn, .strongPullup,
        .slewSelect, .slewReserved, .timeoutActive, .irq);
    lpc_tx_partner i_tx (.clk, .reset, .holdStart, .holdCycles, .transmitInput);
    // Clock
    initial
        forever #5 clk = ~clk;
    // Count and judge one comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus cycle; a read is judged a cycle later
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= w;
        regRead <= !w;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        #1;
        if (!w)
            chk(regRdata, d);
    endtask
    // Settle, then judge the masked pin group
    task automatic pins(input logic [7:0] m, input logic [7:0] exp);
        repeat (4) @(posedge clk);
        #1;
        chk(m & {phyEnabled, transmitterOn, receiverOn, wakeDetectOn,
            strongPullup, timeoutActive, irq, slewReserved}, exp);
    endtask
    // Report and stop
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset values, read-only and factory registers
    task automatic t_regs;
        for (int i = 0; i < 16; i++)
            bus(1'b0, 4'(i), 8'h00);
        bus(1'b1, lpc_pkg::OFF_STATUS, 8'hff);
        bus(1'b0, lpc_pkg::OFF_STATUS, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            specialMode <= i[0];
            bus(1'b1, i[1] ? lpc_pkg::OFF_TEST_B : lpc_pkg::OFF_TEST_A, 8'h5a);
            bus(1'b0, i[1] ? lpc_pkg::OFF_TEST_B : lpc_pkg::OFF_TEST_A, i[0] ? 8'h5a : 8'h00);
        end
        @(posedge clk);
        specialMode <= 1'b0;
    endtask
    // Mode walk: receive-only, normal, standby, shutdown
    task automatic t_modes;
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'hff);
        bus(1'b0, lpc_pkg::OFF_CONTROL, 8'h0f);
        pins(8'hff, 8'ha8);
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h0b);
        pins(8'hff, 8'he8);
        @(posedge clk);
        stopMode <= 1'b1;
        pins(8'h58, 8'h18);
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h09);
        pins(8'h58, 8'h00);
        @(posedge clk);
        stopMode <= 1'b0;
        pins(8'hff, 8'he8);
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h00);
        pins(8'hff, 8'h00);
    endtask
    // Slew codes while off, refusal while on
    task automatic t_slew;
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, lpc_pkg::OFF_SLEW, 8'h7c | 8'(i));
            bus(1'b0, lpc_pkg::OFF_SLEW, 8'(i));
            chk({5'h00, slewReserved, slewSelect}, {5'h00, i == 3, 2'(i)});
        end
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h08);
        bus(1'b1, lpc_pkg::OFF_SLEW, 8'h80);
        bus(1'b0, lpc_pkg::OFF_SLEW, 8'h03);
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h00);
    endtask
    // Dominant stretch past the limit, timeout on or off
    task automatic t_timeout(input logic off);
        bus(1'b1, lpc_pkg::OFF_SLEW, {off, 7'h00});
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h08);
        bus(1'b1, lpc_pkg::OFF_IRQ_MASK, 8'h80);
        @(posedge clk);
        holdCycles <= lpc_pkg::DOM_LIMIT + 16'h00c8;
        holdStart <= 1'b1;
        @(posedge clk);
        holdStart <= 1'b0;
        repeat (lpc_pkg::DOM_LIMIT_CYC + 20) @(posedge clk);
        pins(8'h46, off ? 8'h40 : 8'h06);
        bus(1'b0, lpc_pkg::OFF_STATUS, {~off, 7'h00});
        bus(1'b1, lpc_pkg::OFF_IRQ_FLAG, 8'h80);
        bus(1'b0, lpc_pkg::OFF_IRQ_FLAG, {~off, 7'h00});
        repeat (220) @(posedge clk);
        bus(1'b0, lpc_pkg::OFF_STATUS, 8'h00);
        bus(1'b1, lpc_pkg::OFF_IRQ_FLAG, 8'h00);
        bus(1'b0, lpc_pkg::OFF_IRQ_FLAG, {~off, 7'h00});
        bus(1'b1, lpc_pkg::OFF_IRQ_MASK, 8'h00);
        pins(8'h02, 8'h00);
        bus(1'b1, lpc_pkg::OFF_IRQ_FLAG, 8'h80);
        bus(1'b0, lpc_pkg::OFF_IRQ_FLAG, 8'h00);
        bus(1'b1, lpc_pkg::OFF_CONTROL, 8'h00);
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_modes();
        t_slew();
        t_timeout(1'b0);
        t_timeout(1'b1);
        give_verdict();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule
